// File: spd_deserializer.sv
// Serial pixel deserializer top: mode control, frame assembly, parity and Wishbone registers.
//
// Operation
// - Parity covers 27 payload bits: 24 pixel bits plus both syncs and valid.
// - Odd parity; odd ones count accepts the word and keeps the error low.
// - Even count raises the error pulse at the transition for half a pixel period.
// - Parity is judged only with clock present and multiplier locked.
// - Two lane select bits choose one, two or three lanes; both high reserved.
// - One lane: 30 bits per frame on lane 0; pixel clock divides bit clock by 30.
// - Two lanes: 15 bits from each of lanes 0 and 1, divide by 15.
// - Three lanes: 10 bits from each of lanes 0 to 2.
// - Only the 27 payload bits reach the bus; reserved and parity bits dropped.
// - Enable low: shutdown, link ignored, colors and syncs high, valid and clock low.
// - High clock common mode puts the device in standby with the idle pattern.
// - Link clock below 500 kHz also forces standby.
// - Active needs enable high, clock above 3 MHz and common mode below 1.3 V.
// - While acquiring lock the outputs hold the idle pattern.
// - Once locked, receive mode drives deserialized words and the pixel clock.
// - The reverse select flips the color bit order on the output bus.
// - Order is red, green, blue high to low, or red, green, blue low to high.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module spd_deserializer
  import spd_pkg::*;
(
  // Clock and asynchronous reset.
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link pins and multiplier bit clock.
  input wire logic link_clock_i,
  input wire logic bit_clock_i,
  input wire logic serial_lane_0_i,
  input wire logic serial_lane_1_i,
  input wire logic serial_lane_2_i,
  // Detector indications.
  input wire logic clock_detect_i,
  input wire logic common_mode_high_i,
  input wire logic freq_low_i,
  input wire logic pll_lock_i,
  // Parallel output bus.
  output logic [23:0] color_o,
  output logic vertical_sync_o,
  output logic horizontal_sync_o,
  output logic pixel_valid_o,
  output logic pixel_clock_o,
  output logic parity_error_pulse_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisation.

  logic rst_n_r;
  logic [8:0] sync_q;
  logic link_d_r;
  logic bit_d_r;

  // Reset is released through two flip-flops.
  spd_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(clock_i),
    .rst_n_i(arst_n_i),
    .d_i(1'b1),
    .q_o(rst_n_r)
  );

  // Every link pin and detector passes two flip-flops first.
  spd_sync #(.WIDTH(9)) u_in_sync (
    .clk_i(clock_i),
    .rst_n_i(rst_n_r),
    .d_i({link_clock_i, bit_clock_i, serial_lane_2_i, serial_lane_1_i, serial_lane_0_i,
          clock_detect_i, common_mode_high_i, freq_low_i, pll_lock_i}),
    .q_o(sync_q)
  );

  // Named views of the synchronised inputs.
  wire link_s = sync_q[8];
  wire bit_s = sync_q[7];
  wire [2:0] lane_s = sync_q[6:4];
  wire detect_s = sync_q[3];
  wire cm_high_s = sync_q[2];
  wire freq_low_s = sync_q[1];
  wire lock_s = sync_q[0];

  // Delayed copies for edge detection on the synchronised clocks.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      link_d_r <= 1'b0;
      bit_d_r <= 1'b0;
    end else begin
      link_d_r <= link_s;
      bit_d_r <= bit_s;
    end
  end

  wire link_rise = link_s & ~link_d_r;
  wire bit_rise = bit_s & ~bit_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone registers.

  logic [3:0] ctrl_r;
  logic [SPD_ERRCNT_BITS-1:0] errcnt_r;
  logic [SPD_ERRCNT_BITS-1:0] errcnt_nxt;
  logic ack_r;
  logic [31:0] rdata_r;
  spd_mode_t mode_r;
  spd_mode_t mode_nxt;

  // Address decode and field views.
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wb_wr = wb_req & wb_we_i;
  wire sel_ctrl = (wb_adr_i == SPD_ADDR_CTRL);
  wire sel_stat = (wb_adr_i == SPD_ADDR_STATUS);
  wire sel_errc = (wb_adr_i == SPD_ADDR_ERRCNT);
  wire rx_enable = ctrl_r[SPD_CTRL_ENABLE_BIT];
  wire [1:0] lane_sel = {ctrl_r[SPD_CTRL_LANE_HI_BIT], ctrl_r[SPD_CTRL_LANE_LO_BIT]};
  wire bus_reverse = ctrl_r[SPD_CTRL_REVERSE_BIT];
  wire [31:0] stat_word = {27'h0, lane_sel, lock_s, 2'(mode_r)};
  wire [31:0] rdata_mux = sel_ctrl ? {28'h0, ctrl_r} :
                          sel_stat ? stat_word :
                          sel_errc ? {16'h0, errcnt_r} : 32'h0;

  // One wait state; unmapped reads return zero and unmapped writes vanish.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      ctrl_r <= SPD_CTRL_RESET;
    end else begin
      ack_r <= wb_req;
      rdata_r <= wb_req ? rdata_mux : 32'h0;
      if (wb_wr && sel_ctrl && wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[3:0];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode.

  wire lanes_ok = (lane_sel != 2'h3);
  wire link_idle = cm_high_s | freq_low_s | ~detect_s;

  // Shutdown wins, then standby, then acquire until lock.
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SPD_SHUTDOWN: mode_nxt = rx_enable ? SPD_STANDBY : SPD_SHUTDOWN;
      SPD_STANDBY: mode_nxt = (link_idle || !lanes_ok) ? SPD_STANDBY : SPD_ACQUIRE;
      SPD_ACQUIRE: mode_nxt = lock_s ? SPD_RECEIVE : SPD_ACQUIRE;
      SPD_RECEIVE: mode_nxt = lock_s ? SPD_RECEIVE : SPD_ACQUIRE;
      default: mode_nxt = SPD_SHUTDOWN;
    endcase
    if (mode_r != SPD_SHUTDOWN && (link_idle || !lanes_ok)) begin
      mode_nxt = SPD_STANDBY;
    end
    if (!rx_enable) begin
      mode_nxt = SPD_SHUTDOWN;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= SPD_SHUTDOWN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit shifting and frame counting.

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic frame_ready_r;
  logic half_hit_r;
  logic [29:0] word0;
  logic [29:0] word1;
  logic [29:0] word2;

  // Parity only counts with clock detected and multiplier locked.
  wire rx_on = (mode_r == SPD_RECEIVE) & detect_s & lock_s;
  wire shift_rx = rx_on & bit_rise;
  wire use_lane1 = (lane_sel != SPD_LANES_ONE);
  wire use_lane2 = (lane_sel == SPD_LANES_THREE);
  wire [4:0] frame_len = (lane_sel == SPD_LANES_ONE) ? SPD_LEN_ONE :
                         (lane_sel == SPD_LANES_TWO) ? SPD_LEN_TWO : SPD_LEN_THREE;
  wire [4:0] half_len = (lane_sel == SPD_LANES_ONE) ? SPD_HALF_ONE :
                        (lane_sel == SPD_LANES_TWO) ? SPD_HALF_TWO : SPD_HALF_THREE;
  wire [4:0] cnt_cur = link_rise ? 5'h00 : cnt_r;
  wire last_bit = shift_rx && (cnt_cur == frame_len - 5'h01);
  wire half_bit = shift_rx && (cnt_cur == half_len - 5'h01);

  // Lane receivers shift only in receive mode and only when selected.
  spd_lane_shift #(.WIDTH(SPD_FRAME_BITS)) u_lane0 (
    .clk_i(clock_i),
    .rst_n_i(rst_n_r),
    .shift_i(shift_rx),
    .bit_i(lane_s[0]),
    .word_o(word0)
  );

  spd_lane_shift #(.WIDTH(SPD_FRAME_BITS)) u_lane1 (
    .clk_i(clock_i),
    .rst_n_i(rst_n_r),
    .shift_i(shift_rx & use_lane1),
    .bit_i(lane_s[1]),
    .word_o(word1)
  );

  spd_lane_shift #(.WIDTH(SPD_FRAME_BITS)) u_lane2 (
    .clk_i(clock_i),
    .rst_n_i(rst_n_r),
    .shift_i(shift_rx & use_lane2),
    .bit_i(lane_s[2]),
    .word_o(word2)
  );

  // Bit counter restarts on each link clock rise and wraps at the frame end.
  always_comb begin
    cnt_nxt = cnt_r;
    if (!rx_on) begin
      cnt_nxt = 5'h00;
    end else if (shift_rx) begin
      cnt_nxt = last_bit ? 5'h00 : 5'(cnt_cur + 5'h01);
    end else if (link_rise) begin
      cnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= 5'h00;
      frame_ready_r <= 1'b0;
      half_hit_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      frame_ready_r <= last_bit;
      half_hit_r <= half_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly, parity and output bus.

  // Lane words concatenate, lane 0 first, into one 30-bit frame.
  wire [29:0] frame = (lane_sel == SPD_LANES_ONE) ? word0 :
                      (lane_sel == SPD_LANES_TWO) ? {word0[14:0], word1[14:0]} :
                      {word0[9:0], word1[9:0], word2[9:0]};
  wire [26:0] payload = frame[SPD_FRAME_BITS-1:SPD_FRAME_BITS-SPD_PAYLOAD_BITS];
  wire parity_ok = ^{payload, frame[SPD_PARITY_POS]};
  wire take_word = frame_ready_r & rx_on & parity_ok;
  wire bad_word = frame_ready_r & rx_on & ~parity_ok;
  wire [23:0] colors = payload[26:3];
  wire [23:0] colors_rev = {<<{colors}};

  // Idle pattern outside receive; new word only when parity holds.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      color_o <= 24'hFFFFFF;
      vertical_sync_o <= 1'b1;
      horizontal_sync_o <= 1'b1;
      pixel_valid_o <= 1'b0;
    end else if (!rx_on) begin
      color_o <= 24'hFFFFFF;
      vertical_sync_o <= 1'b1;
      horizontal_sync_o <= 1'b1;
      pixel_valid_o <= 1'b0;
    end else if (take_word) begin
      color_o <= bus_reverse ? colors_rev : colors;
      vertical_sync_o <= payload[2];
      horizontal_sync_o <= payload[1];
      pixel_valid_o <= payload[0];
    end
  end

  // Pixel clock rises with each frame, falls at mid-frame; error pulse alike.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pixel_clock_o <= 1'b0;
      parity_error_pulse_o <= 1'b0;
    end else if (!rx_on) begin
      pixel_clock_o <= 1'b0;
      parity_error_pulse_o <= 1'b0;
    end else if (frame_ready_r) begin
      pixel_clock_o <= 1'b1;
      parity_error_pulse_o <= bad_word;
    end else if (half_hit_r) begin
      pixel_clock_o <= 1'b0;
      parity_error_pulse_o <= 1'b0;
    end
  end

  // Error counter: a write clears it, but an error in that cycle still counts.
  always_comb begin
    errcnt_nxt = errcnt_r;
    if (wb_wr && sel_errc) begin
      errcnt_nxt = '0;
    end
    if (bad_word) begin
      errcnt_nxt = (wb_wr && sel_errc) ? 16'h0001 : 16'(errcnt_r + 16'h0001);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      errcnt_r <= '0;
    end else begin
      errcnt_r <= errcnt_nxt;
    end
  end

endmodule
`default_nettype wire

// File: spd_pkg.sv
// Shared constants and types for the serial pixel deserializer.
package spd_pkg;

  // Wishbone register byte offsets.
  localparam logic [7:0] SPD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SPD_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SPD_ADDR_ERRCNT = 8'h08;

  // Control register field positions and reset value.
  localparam int SPD_CTRL_ENABLE_BIT = 0;
  localparam int SPD_CTRL_LANE_LO_BIT = 1;
  localparam int SPD_CTRL_LANE_HI_BIT = 2;
  localparam int SPD_CTRL_REVERSE_BIT = 3;
  localparam logic [3:0] SPD_CTRL_RESET = 4'h0;

  // Status register field positions.
  localparam int SPD_STAT_MODE_LSB = 0;
  localparam int SPD_STAT_LOCK_BIT = 2;
  localparam int SPD_STAT_LANE_LSB = 3;

  // Lane select encodings, high bit first.
  localparam logic [1:0] SPD_LANES_ONE = 2'h0;
  localparam logic [1:0] SPD_LANES_TWO = 2'h1;
  localparam logic [1:0] SPD_LANES_THREE = 2'h2;

  // Frame geometry.
  localparam int SPD_FRAME_BITS = 30;
  localparam int SPD_PAYLOAD_BITS = 27;
  localparam int SPD_COLOR_BITS = 24;
  localparam int SPD_PARITY_POS = 2;
  localparam int SPD_ERRCNT_BITS = 16;

  // Bits per lane per frame and half-frame points, per lane mode.
  localparam logic [4:0] SPD_LEN_ONE = 5'h1E;
  localparam logic [4:0] SPD_LEN_TWO = 5'h0F;
  localparam logic [4:0] SPD_LEN_THREE = 5'h0A;
  localparam logic [4:0] SPD_HALF_ONE = 5'h0F;
  localparam logic [4:0] SPD_HALF_TWO = 5'h07;
  localparam logic [4:0] SPD_HALF_THREE = 5'h05;

  // Operating modes.
  typedef enum logic [1:0] {
    SPD_SHUTDOWN,
    SPD_STANDBY,
    SPD_ACQUIRE,
    SPD_RECEIVE
  } spd_mode_t;

endpackage

// File: spd_sync.sv
// Two-flip-flop synchroniser for a group of level inputs.
`timescale 1ns/10ps
`default_nettype none
module spd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: spd_lane_shift.sv
// Serial-in shift register for one data lane.
`timescale 1ns/10ps
`default_nettype none
module spd_lane_shift #(
  parameter int WIDTH = 30
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial bit and its shift strobe.
  input wire logic shift_i,
  input wire logic bit_i,
  // Collected bits, newest in bit 0.
  output logic [WIDTH-1:0] word_o
);

  // Shift one bit in on each strobe, first bit ending at the top.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_o <= '0;
    end else if (shift_i) begin
      word_o <= {word_o[WIDTH-2:0], bit_i};
    end
  end

endmodule
`default_nettype wire

// File: spd_deserializer_properties.sv
// Port-level checker for the serial pixel deserializer, bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module spd_deserializer_checker
  import spd_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Wishbone side.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Parallel output side.
  input wire logic [23:0] color_o,
  input wire logic pixel_valid_o,
  input wire logic pixel_clock_o,
  input wire logic parity_error_pulse_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // A taken request is answered one cycle later, and only by a single pulse.
  ack_timing_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");

  ////////////////////////////////////////////////////////////////////////////
  // The error pulse rises with the recovered clock and keeps the old word.
  err_rise_a: assert property ($rose(parity_error_pulse_o) |-> $rose(pixel_clock_o))
    else $error("error pulse not aligned to pixel clock rise");
  err_hold_data_a: assert property ($rose(parity_error_pulse_o) |-> $stable(color_o))
    else $error("bad word reached the bus");
  err_width_a: assert property ($rose(parity_error_pulse_o) |=> parity_error_pulse_o[*8])
    else $error("error pulse too short");
  err_clear_a: assert property ($fell(parity_error_pulse_o) |-> $fell(pixel_clock_o))
    else $error("error pulse not cleared with pixel clock");
  err_with_clock_a: assert property (parity_error_pulse_o |-> pixel_clock_o)
    else $error("error pulse without recovered clock");

  ////////////////////////////////////////////////////////////////////////////
  // Clearing the enable brings the static idle pattern within a few cycles.
  shutdown_idle_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == SPD_ADDR_CTRL
    && wb_sel_i[0] && !wb_dat_i[0]) |-> ##[1:4] (color_o == 24'hFFFFFF && !pixel_valid_o && !pixel_clock_o))
    else $error("shutdown pattern not shown");
endmodule

bind spd_deserializer spd_deserializer_checker u_spd_deserializer_checker (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .color_o(color_o), .pixel_valid_o(pixel_valid_o),
  .pixel_clock_o(pixel_clock_o), .parity_error_pulse_o(parity_error_pulse_o)
);
`default_nettype wire

// File: spd_tx_model.sv
// Behavioural serial video transmitter with its bit clock, driving the link lanes.
`timescale 1ns/10ps
`default_nettype none
module spd_tx_model (
  // System clock for pacing.
  input wire logic clock_i,
  // Link clock, bit clock and data lanes.
  output logic link_clock_o,
  output logic bit_clock_o,
  output logic [2:0] lane_o
);
  // Clocks stand low outside frames.
  initial begin
    link_clock_o = 1'b0;
    bit_clock_o = 1'b0;
    lane_o = 3'h0;
  end

  // Sends one frame, n bits per lane, most significant first; idle lanes toggle.
  task automatic send(input logic [29:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clock_i);
      link_clock_o <= (k < n / 2);
      bit_clock_o <= 1'b0;
      for (int j = 0; j < 3; j++) lane_o[j] <= (j * n < 30) ? f[29 - j * n - k] : ~lane_o[j];
      repeat (4) @(posedge clock_i);
      bit_clock_o <= 1'b1;
      repeat (3) @(posedge clock_i);
    end
    @(posedge clock_i);
    link_clock_o <= 1'b0;
    bit_clock_o <= 1'b0;
    lane_o <= ~lane_o;
  endtask
endmodule
`default_nettype wire

// File: spd_deserializer_bench.sv
// Self-checking bench for the serial pixel deserializer.
`timescale 1ns/10ps
`default_nettype none
module spd_deserializer_bench
  import spd_pkg::*;
;
  localparam logic [27:0] IDLE = 28'hFFFFFFC;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic link_clock, bit_clock, vsync, hsync, valid, pclk, perr;
  logic [2:0] lane;
  logic clock_detect = 1'b0, cm_high = 1'b0, freq_low = 1'b0, lock = 1'b0;
  logic [23:0] color;
  logic [26:0] p;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #20 clock = ~clock;

  spd_deserializer u_spd_deserializer (.clock_i(clock), .arst_n_i(arst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_clock_i(link_clock), .bit_clock_i(bit_clock),
    .serial_lane_0_i(lane[0]), .serial_lane_1_i(lane[1]), .serial_lane_2_i(lane[2]),
    .clock_detect_i(clock_detect), .common_mode_high_i(cm_high), .freq_low_i(freq_low),
    .pll_lock_i(lock), .color_o(color), .vertical_sync_o(vsync), .horizontal_sync_o(hsync),
    .pixel_valid_o(valid), .pixel_clock_o(pclk), .parity_error_pulse_o(perr));
  spd_tx_model u_spd_tx_model (.clock_i(clock), .link_clock_o(link_clock), .bit_clock_o(bit_clock),
    .lane_o(lane));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus helpers.
  task automatic end_sim;
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle: held until ack is seen high at a rising edge, then one idle cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    do @(posedge clock); while (wb_ack !== 1'b1); // Reads here see the values sampled at that edge.
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic outs(input logic [27:0] e);
    chk({4'h0, color, vsync, hsync, valid, pclk}, {4'h0, e}, "output bus");
  endtask

  // Odd parity makes the count of ones over payload and parity bit odd.
  function automatic logic [29:0] mk(input logic [26:0] d, input logic bad);
    return {d, ~^d ^ bad, 2'h0};
  endfunction

  function automatic logic [23:0] rev(input logic [23:0] c);
    for (int i = 0; i < 24; i++) rev[i] = c[23 - i];
  endfunction

  task automatic frame(input logic [29:0] f, input int l);
    u_spd_tx_model.send(f, (l == 0) ? 30 : (l == 1) ? 15 : 10);
    repeat (10) @(posedge clock);
  endtask

  // Hang guard.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    outs(IDLE);
    rd_chk(SPD_ADDR_CTRL, 32'h0, "ctrl reset");
    rd_chk(SPD_ADDR_STATUS, 32'h0, "shutdown");
    rd_chk(8'h0C, 32'h0, "unmapped");
    wb(1'b1, SPD_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      {cm_high, freq_low, clock_detect} <= (i == 0) ? 3'h0 : (i == 1) ? 3'h5 : 3'h3;
      repeat (6) @(posedge clock);
      rd_chk(SPD_ADDR_STATUS, 32'h1, "standby");
      outs(IDLE);
    end
    // The detectors only ever report a link clock in its valid range while the receiver runs.
    {cm_high, freq_low, clock_detect} <= 3'h1;
    repeat (6) @(posedge clock);
    rd_chk(SPD_ADDR_STATUS, 32'h2, "acquire");
    outs(IDLE);
    lock <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(SPD_ADDR_STATUS, 32'h7, "receive");
    for (int l = 0; l < 3; l++) begin
      wb(1'b1, SPD_ADDR_CTRL, 32'(l * 2 + 1));
      p = 27'(27'h2A5C3E1 + l * 27'h0F0F0F3);
      frame(mk(p, 1'b0), l);
      outs({p, 1'b1});
    end
    rd_chk(SPD_ADDR_ERRCNT, 32'h0, "no errors");
    frame(mk(~p, 1'b0) ^ 30'h8, 2);
    outs({p, 1'b1});
    chk({31'h0, perr}, 32'h1, "error pulse");
    frame(mk(~p, 1'b0) ^ 30'h20000000, 2);
    rd_chk(SPD_ADDR_ERRCNT, 32'h2, "two errors");
    wb(1'b1, SPD_ADDR_ERRCNT, 32'h0);
    rd_chk(SPD_ADDR_ERRCNT, 32'h0, "count cleared");
    wb(1'b1, SPD_ADDR_CTRL, 32'hD);
    p = 27'h1C3A5F6;
    frame(mk(p, 1'b0), 2);
    outs({rev(p[26:3]), p[2:0], 1'b1});
    chk({31'h0, perr}, 32'h0, "error pulse not cleared");
    wb(1'b1, SPD_ADDR_CTRL, 32'h7);
    repeat (6) @(posedge clock);
    rd_chk(SPD_ADDR_STATUS, 32'h1D, "reserved lanes");
    outs(IDLE);
    wb(1'b1, SPD_ADDR_CTRL, 32'h1);
    lock <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(SPD_ADDR_STATUS, 32'h2, "lock lost");
    frame(mk(p, 1'b1), 0);
    rd_chk(SPD_ADDR_ERRCNT, 32'h0, "no check unlocked");
    outs(IDLE);
    lock <= 1'b1;
    wb(1'b1, SPD_ADDR_CTRL, 32'h0);
    repeat (260) @(posedge clock);
    rd_chk(SPD_ADDR_STATUS, 32'h4, "back to shutdown");
    frame(mk(p, 1'b0), 0);
    outs(IDLE);
    end_sim();
  end
endmodule
`default_nettype wire
